// [mcs_core.sv]
// Purpose: Branch, control, move, I/O, call and timer execution core.
// Assumes: Inputs synchronous to mclk; memory reads answer at once.
// Notes: One machine cycle per mclk; other opcodes act as no-ops.
`timescale 1ns/1ps
`include "mcs_regs.svh"

module mcs_core (
  input  wire logic        mclk,
  input  wire logic        rst,
  output logic [11:0]      progAddr,
  input  wire logic [7:0]  progData,
  output logic [7:0]       xAddr,
  output logic [7:0]       xWrData,
  input  wire logic [7:0]  xRdData,
  output logic             xRd,
  output logic             xWr,
  input  wire logic [7:0]  p1In,
  input  wire logic [7:0]  p2In,
  output logic [7:0]       p1Out,
  output logic [7:0]       p2Out,
  input  wire logic [7:0]  busIn,
  output logic [7:0]       busOut,
  output logic             busOe,
  output logic             busRd,
  output logic             busWr,
  output logic [1:0]       expSel,
  output logic [3:0]       expWrData,
  input  wire logic [3:0]  expRdData,
  output logic             expWr,
  input  wire logic        testPinAIn,
  output logic             testPinAOut,
  output logic             testPinAOe,
  input  wire logic        testPinB,
  input  wire logic        extIrqN,
  output logic             extIrqReq,
  output logic             timerIrqReq,
  output logic             timerFlag
);

  mcs_pkg::mcs_state_t stQ;
  mcs_pkg::mcs_mode_t  modeQ;
  logic [11:0]         pcQ;
  logic [7:0]          accQ;
  logic [7:0]          pswQ;
  logic [7:0]          opQ;
  logic [7:0]          tmrQ;
  logic [7:0]          p1Q;
  logic [7:0]          p2Q;
  logic [7:0]          busQ;
  logic [7:0]          xAddrQ;
  logic [7:0]          xDataQ;
  logic [3:0]          expDataQ;
  logic [1:0]          expSelQ;
  logic [4:0]          preQ;
  logic                busOeQ;
  logic                busWrQ;
  logic                expWrQ;
  logic                f1Q;
  logic                mbQ;
  logic                xIrqEnQ;
  logic                tIrqEnQ;
  logic                clkOutQ;
  logic                stClkQ;
  logic                tfQ;
  logic                tbPrevQ;
  logic                xReqQ;
  logic                tReqQ;
  logic [7:0]          ram [0:127];

  wire logic        sec = (stQ == mcs_pkg::ST_SECOND);
  wire logic        fet = ~sec;
  wire logic [7:0]  op  = progData;
  wire logic [6:0]  rBase =
    pswQ[`PSW_BS] ? `RBANK1_BASE : `RBANK0_BASE;
  wire logic [6:0]  rAddr = rBase | {6'h00, op[0]};
  wire logic [6:0]  ptr = ram[rAddr][6:0];
  wire logic [2:0]  sp = pswQ[`PSW_SP];
  wire logic [2:0]  spDn = sp - 3'h1;
  wire logic [6:0]  pushLo = `STACK_BASE + {3'h0, sp, 1'b0};
  wire logic [6:0]  pushHi = pushLo | 7'h01;
  wire logic [6:0]  popLo = `STACK_BASE + {3'h0, spDn, 1'b0};
  wire logic [6:0]  popHi = popLo | 7'h01;
  wire logic [11:0] pcInc = pcQ + 12'h001;
  wire logic [11:0] jmpTgt = {mbQ, opQ[7:5], progData};
  wire logic [11:0] pageTgt = {pcQ[11:8], progData};
  wire logic        isAnd = opQ[`AND_BIT];
  wire logic [7:0]  portIn = opQ[1] ? p2In : p1In;
  wire logic [7:0]  portRes =
    isAnd ? (portIn & progData) : (portIn | progData);
  wire logic [7:0]  busRes =
    isAnd ? (busQ & progData) : (busQ | progData);
  wire logic [3:0]  expRes =
    isAnd ? (expRdData & accQ[3:0]) : (expRdData | accQ[3:0]);
  wire logic        callW = sec & (opQ ==? `OP_CALL);
  wire logic        swapW = fet & (op ==? `OP_NSWAP);
  wire logic        tmrLd = fet & (op == `OP_TMR_A);
  wire logic        tfClr = sec & (opQ == `OP_BR_TOF);
  wire logic        tick =
    (modeQ == mcs_pkg::CNT_TIMER) & (preQ == `TMR_PRE_END);
  wire logic        evt =
    (modeQ == mcs_pkg::CNT_EVENT) & tbPrevQ & ~testPinB;
  wire logic        inc = tick | evt;
  wire logic        ovf = inc & (tmrQ == `TMR_MAX);
  logic             brTaken;

  assign brTaken =
    (opQ == `OP_BR_TA0) ? ~testPinAIn :
    (opQ == `OP_BR_TA1) ? testPinAIn :
    (opQ == `OP_BR_TB0) ? ~testPinB :
    (opQ == `OP_BR_TB1) ? testPinB :
    (opQ == `OP_BR_NZ) ? (accQ != 8'h00) :
    (opQ == `OP_BR_Z) ? (accQ == 8'h00) :
    tfQ;

  // Table reads borrow the address lines in their second cycle
  assign progAddr =
    (sec && opQ == `OP_TBL) ? {pcQ[11:8], accQ} :
    (sec && opQ == `OP_TBL3) ? {pcQ[11], `PAGE3, accQ} :
    pcQ;

  assign xAddr       = xAddrQ;
  assign xWrData     = xDataQ;
  assign xRd         = sec & (opQ ==? `OP_XRD);
  assign xWr         = sec & (opQ ==? `OP_XWR);
  assign p1Out       = p1Q;
  assign p2Out       = p2Q;
  assign busOut      = busQ;
  assign busOe       = busOeQ;
  assign busRd       = sec & (opQ == `OP_BUS_IN);
  assign busWr       = busWrQ;
  assign expSel      = expSelQ;
  assign expWrData   = expDataQ;
  assign expWr       = expWrQ;
  assign testPinAOut = stClkQ;
  assign testPinAOe  = clkOutQ;
  assign extIrqReq   = xReqQ;
  assign timerIrqReq = tReqQ;
  assign timerFlag   = tfQ;

  // Internal data memory, no reset
  always_ff @(posedge mclk)
  begin
    if (swapW)
      ram[ptr] <= {ram[ptr][7:4], accQ[3:0]};
    if (callW)
    begin
      ram[pushLo] <= pcInc[7:0];
      ram[pushHi] <= {pswQ[`PSW_HI], pcInc[11:8]};
    end
  end

  // Timer, counter and interrupt request flops
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      modeQ   <= mcs_pkg::CNT_STOP;
      tmrQ    <= 8'h00;
      preQ    <= 5'h00;
      tfQ     <= 1'b0;
      tbPrevQ <= 1'b0;
      stClkQ  <= 1'b0;
      xReqQ   <= 1'b0;
      tReqQ   <= 1'b0;
    end
    else
    begin
      tbPrevQ <= testPinB;
      stClkQ  <= ~stClkQ;
      preQ    <= preQ + 5'h01;
      if (fet && op == `OP_CNT_EVT)
        modeQ <= mcs_pkg::CNT_EVENT;
      if (fet && op == `OP_CNT_TMR)
      begin
        modeQ <= mcs_pkg::CNT_TIMER;
        preQ  <= 5'h00;
      end
      if (fet && op == `OP_CNT_STOP)
        modeQ <= mcs_pkg::CNT_STOP;
      if (tmrLd)
        tmrQ <= accQ;
      else if (inc)
        tmrQ <= tmrQ + 8'h01;
      // Overflow wins over the clear by the flag branch
      tfQ   <= ovf | (tfQ & ~tfClr);
      xReqQ <= xIrqEnQ & ~extIrqN;
      tReqQ <= tIrqEnQ & (ovf | tfQ);
    end
  end

  // Instruction sequencing
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      stQ      <= mcs_pkg::ST_FETCH;
      pcQ      <= 12'h000;
      accQ     <= 8'h00;
      pswQ     <= `PSW_RST;
      opQ      <= 8'h00;
      p1Q      <= 8'hff;
      p2Q      <= 8'hff;
      busQ     <= 8'h00;
      busOeQ   <= 1'b0;
      busWrQ   <= 1'b0;
      xAddrQ   <= 8'h00;
      xDataQ   <= 8'h00;
      expSelQ  <= 2'h0;
      expDataQ <= 4'h0;
      expWrQ   <= 1'b0;
      f1Q      <= 1'b0;
      mbQ      <= 1'b0;
      xIrqEnQ  <= 1'b0;
      tIrqEnQ  <= 1'b0;
      clkOutQ  <= 1'b0;
    end
    else if (fet)
    begin
      pcQ    <= pcInc;
      opQ    <= op;
      busWrQ <= 1'b0;
      expWrQ <= 1'b0;
      unique casez (op)
        `OP_BR_TA0, `OP_BR_TA1, `OP_BR_TB0, `OP_BR_TB1,
        `OP_BR_NZ, `OP_BR_Z, `OP_BR_TOF, `OP_JUMP, `OP_CALL,
        `OP_BACK, `OP_BACK_RS, `OP_TBL, `OP_TBL3, `OP_BUS_IN,
        `OP_BUS_AND, `OP_BUS_OR, `OP_P1_AND, `OP_P2_AND,
        `OP_P1_OR, `OP_P2_OR:
          stQ <= mcs_pkg::ST_SECOND;
        `OP_XRD, `OP_XWR:
        begin
          stQ    <= mcs_pkg::ST_SECOND;
          xAddrQ <= ram[rAddr];
          xDataQ <= accQ;
        end
        `OP_EXP_RD, `OP_EXP_AND, `OP_EXP_OR:
        begin
          stQ     <= mcs_pkg::ST_SECOND;
          expSelQ <= op[1:0];
        end
        `OP_EXP_WR:
        begin
          expSelQ  <= op[1:0];
          expDataQ <= accQ[3:0];
          expWrQ   <= 1'b1;
        end
        `OP_BUS_OUT:
        begin
          busQ   <= accQ;
          busOeQ <= 1'b1;
          busWrQ <= 1'b1;
        end
        `OP_XIRQ_EN:
          xIrqEnQ <= 1'b1;
        `OP_XIRQ_DIS:
          xIrqEnQ <= 1'b0;
        `OP_TIRQ_EN:
          tIrqEnQ <= 1'b1;
        `OP_TIRQ_DIS:
          tIrqEnQ <= 1'b0;
        `OP_CLK_OUT:
          clkOutQ <= 1'b1;
        `OP_PBANK0:
          mbQ <= 1'b0;
        `OP_PBANK1:
          mbQ <= 1'b1;
        `OP_RBANK0:
          pswQ[`PSW_BS] <= 1'b0;
        `OP_RBANK1:
          pswQ[`PSW_BS] <= 1'b1;
        `OP_A_PSW:
          accQ <= pswQ;
        `OP_PSW_A:
          pswQ <= accQ | `PSW_FIXED;
        `OP_NSWAP:
          accQ[3:0] <= ram[ptr][3:0];
        `OP_A_TMR:
          accQ <= tmrQ;
        `OP_CPL_C:
          pswQ[`PSW_CY] <= ~pswQ[`PSW_CY];
        `OP_CLR_C:
          pswQ[`PSW_CY] <= 1'b0;
        `OP_CPL_FA:
          pswQ[`PSW_FA] <= ~pswQ[`PSW_FA];
        `OP_CLR_FA:
          pswQ[`PSW_FA] <= 1'b0;
        `OP_CPL_FB:
          f1Q <= ~f1Q;
        `OP_CLR_FB:
          f1Q <= 1'b0;
        default:
          ;
      endcase
    end
    else
    begin
      stQ    <= mcs_pkg::ST_FETCH;
      busWrQ <= 1'b0;
      expWrQ <= 1'b0;
      unique casez (opQ)
        `OP_BR_TA0, `OP_BR_TA1, `OP_BR_TB0, `OP_BR_TB1,
        `OP_BR_NZ, `OP_BR_Z, `OP_BR_TOF:
          pcQ <= brTaken ? pageTgt : pcInc;
        `OP_JUMP:
          pcQ <= jmpTgt;
        `OP_CALL:
        begin
          pcQ           <= jmpTgt;
          pswQ[`PSW_SP] <= sp + 3'h1;
        end
        `OP_BACK, `OP_BACK_RS:
        begin
          pcQ           <= {ram[popHi][3:0], ram[popLo]};
          pswQ[`PSW_SP] <= spDn;
          if (opQ == `OP_BACK_RS)
            pswQ[`PSW_HI] <= ram[popHi][7:4];
        end
        `OP_TBL, `OP_TBL3:
          accQ <= progData;
        `OP_XRD:
          accQ <= xRdData;
        `OP_BUS_IN:
        begin
          accQ   <= busIn;
          busOeQ <= 1'b0;
        end
        `OP_BUS_AND, `OP_BUS_OR:
        begin
          pcQ  <= pcInc;
          busQ <= busRes;
        end
        `OP_P1_AND, `OP_P2_AND, `OP_P1_OR, `OP_P2_OR:
        begin
          pcQ <= pcInc;
          if (opQ[1])
            p2Q <= portRes;
          else
            p1Q <= portRes;
        end
        `OP_EXP_RD:
          accQ <= {4'h0, expRdData};
        `OP_EXP_AND, `OP_EXP_OR:
        begin
          expDataQ <= expRes;
          expWrQ   <= 1'b1;
        end
        default:
          ;
      endcase
    end
  end

endmodule : mcs_core

// [mcs_regs.svh]
// Purpose: Opcodes, field positions, reset values and counts.
// Assumes: Included by the core only.
// Notes: Patterns with ? are matched by casez or ==?.
`ifndef MCS_REGS_SVH
`define MCS_REGS_SVH
`define OP_BR_TA0   8'h26
`define OP_BR_TA1   8'h36
`define OP_BR_TB0   8'h46
`define OP_BR_TB1   8'h56
`define OP_BR_NZ    8'h96
`define OP_BR_Z     8'hc6
`define OP_BR_TOF   8'h16
`define OP_JUMP     8'b???0_0100
`define OP_CALL     8'b???1_0100
`define OP_BACK     8'h83
`define OP_BACK_RS  8'h93
`define OP_XIRQ_EN  8'h05
`define OP_XIRQ_DIS 8'h15
`define OP_CLK_OUT  8'h75
`define OP_PBANK0   8'he5
`define OP_PBANK1   8'hf5
`define OP_RBANK0   8'hc5
`define OP_RBANK1   8'hd5
`define OP_A_PSW    8'hc7
`define OP_PSW_A    8'hd7
`define OP_TBL      8'ha3
`define OP_TBL3     8'he3
`define OP_XRD      8'b1000_000?
`define OP_XWR      8'b1001_000?
`define OP_NSWAP    8'b0011_000?
`define OP_EXP_RD   8'b0000_11??
`define OP_EXP_WR   8'b0011_11??
`define OP_EXP_AND  8'b1001_11??
`define OP_EXP_OR   8'b1000_11??
`define OP_BUS_IN   8'h08
`define OP_BUS_OUT  8'h02
`define OP_BUS_AND  8'h98
`define OP_BUS_OR   8'h88
`define OP_P1_AND   8'h99
`define OP_P2_AND   8'h9a
`define OP_P1_OR    8'h89
`define OP_P2_OR    8'h8a
`define OP_TIRQ_EN  8'h25
`define OP_TIRQ_DIS 8'h35
`define OP_A_TMR    8'h42
`define OP_TMR_A    8'h62
`define OP_CNT_STOP 8'h65
`define OP_CNT_EVT  8'h45
`define OP_CNT_TMR  8'h55
`define OP_CPL_C    8'ha7
`define OP_CPL_FA   8'h95
`define OP_CPL_FB   8'hb5
`define OP_CLR_C    8'h97
`define OP_CLR_FA   8'h85
`define OP_CLR_FB   8'ha5
`define AND_BIT     4
`define PSW_CY      7
`define PSW_FA      5
`define PSW_BS      4
`define PSW_HI      7:4
`define PSW_SP      2:0
`define PSW_FIXED   8'h08
`define PSW_RST     8'h08
`define RBANK0_BASE 7'h00
`define RBANK1_BASE 7'h18
`define STACK_BASE  7'h08
`define PAGE3       3'h3
`define TMR_PRE_END 5'h1f
`define TMR_MAX     8'hff
`endif

// [mcs_pkg.sv]
// Purpose: Types shared by the controller core.
// Assumes: Nothing.
// Notes: Constants live in mcs_regs.svh.
package mcs_pkg;
  typedef enum logic {ST_FETCH, ST_SECOND} mcs_state_t;
  typedef enum logic [1:0] {CNT_STOP, CNT_TIMER, CNT_EVENT} mcs_mode_t;
endpackage : mcs_pkg

// [mcs_core_properties.sv]
// Purpose: Port checks for the controller core.
// Assumes: One clock; rst async, active high.
// Notes: Bound into every mcs_core.
`timescale 1ns/1ps
module mcs_core_properties (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic [7:0] progData,
  input wire logic       xRd,
  input wire logic       xWr,
  input wire logic       busRd,
  input wire logic       busWr,
  input wire logic       busOe,
  input wire logic       testPinAOut,
  input wire logic       testPinAOe,
  input wire logic       extIrqN,
  input wire logic       extIrqReq,
  input wire logic       timerFlag
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  property p_xrd;
    xRd |-> ($past(progData) & 8'hfe) == 8'h80;
  endproperty
  a_xrd: assert property (p_xrd)
    else $error("read strobe without opcode");
  property p_xwr;
    xWr |-> ($past(progData) & 8'hfe) == 8'h90;
  endproperty
  a_xwr: assert property (p_xwr)
    else $error("write strobe without opcode");
  property p_xpulse;
    (xRd || xWr) |=> !(xRd || xWr);
  endproperty
  a_xpulse: assert property (p_xpulse)
    else $error("data strobe too long");
  property p_busrd;
    busRd |-> ($past(progData) == 8'h08) ##1 !busOe;
  endproperty
  a_busrd: assert property (p_busrd)
    else $error("bus read strobe wrong");
  property p_buswr;
    busWr |-> busOe && $past(progData) == 8'h02;
  endproperty
  a_buswr: assert property (p_buswr)
    else $error("bus write strobe wrong");
  property p_clkon;
    $rose(testPinAOe) |-> $past(progData) == 8'h75;
  endproperty
  a_clkon: assert property (p_clkon)
    else $error("clock output enabled without opcode");
  property p_clkrun;
    testPinAOe |=> testPinAOe && testPinAOut != $past(testPinAOut);
  endproperty
  a_clkrun: assert property (p_clkrun)
    else $error("clock output not running");
  property p_xirq;
    extIrqReq |-> !$past(extIrqN);
  endproperty
  a_xirq: assert property (p_xirq)
    else $error("interrupt request without input");
  property p_tfclr;
    $fell(timerFlag) |->
      $past(progData) == 8'h16 || $past(progData, 2) == 8'h16;
  endproperty
  a_tfclr: assert property (p_tfclr)
    else $error("timer flag cleared without branch");
endmodule : mcs_core_properties

bind mcs_core mcs_core_properties mcs_core_properties_i (
  .mclk(mclk), .rst(rst), .progData(progData), .xRd(xRd), .xWr(xWr),
  .busRd(busRd), .busWr(busWr), .busOe(busOe),
  .testPinAOut(testPinAOut), .testPinAOe(testPinAOe),
  .extIrqN(extIrqN), .extIrqReq(extIrqReq), .timerFlag(timerFlag)
);

// [mcs_ext_model.sv]
// Purpose: Program memory, external data memory, expander ports.
// Assumes: Memories answer in the same cycle.
// Notes: Bench loads rom while the core is in reset.
`timescale 1ns/1ps
module mcs_ext_model (
  input  wire logic        mclk,
  input  wire logic [11:0] progAddr,
  output logic [7:0]       progData,
  input  wire logic [7:0]  xAddr,
  input  wire logic [7:0]  xWrData,
  output logic [7:0]       xRdData,
  input  wire logic        xRd,
  input  wire logic        xWr,
  input  wire logic [1:0]  expSel,
  input  wire logic [3:0]  expWrData,
  output logic [3:0]       expRdData,
  input  wire logic        expWr
);
  logic [7:0] rom  [0:4095];
  logic [7:0] xMem [0:255];
  logic [3:0] expQ [0:3];
  assign progData  = rom[progAddr];
  // Idle data lines show the inverse
  assign xRdData   = xRd ? xMem[xAddr] : ~xMem[xAddr];
  assign expRdData = expQ[expSel];
  always @(posedge mclk)
  begin
    if (xWr)
      xMem[xAddr] <= xWrData;
    if (expWr)
      expQ[expSel] <= expWrData;
  end
endmodule : mcs_ext_model

// [test_microcontroller_instruction_set.sv]
// Purpose: Self-checking bench for the controller core.
// Assumes: Program memory model answers in the same cycle.
// Notes: Each scenario resets the core, loads a program, then releases reset.
`timescale 1ns/1ps
module test_microcontroller_instruction_set;
  logic        mclk, rst, xRd, xWr, busOe, busRd, busWr, expWr;
  logic        testPinAIn, testPinAOut, testPinAOe, testPinB, extIrqN;
  logic        extIrqReq, timerIrqReq, timerFlag, sawTirq, pinA;
  logic [11:0] progAddr;
  logic [7:0]  progData, xAddr, xWrData, xRdData, p1In, p2In;
  logic [7:0]  p1Out, p2Out, busIn, busOut;
  logic [1:0]  expSel;
  logic [3:0]  expWrData, expRdData;
  int          n_mismatch, n_compared, cyc;
  logic [7:0]  outs [$];
  logic [7:0]  xw [$];

  mcs_core mcs_core_i (
    .mclk(mclk), .rst(rst), .progAddr(progAddr), .progData(progData),
    .xAddr(xAddr), .xWrData(xWrData), .xRdData(xRdData), .xRd(xRd),
    .xWr(xWr), .p1In(p1In), .p2In(p2In), .p1Out(p1Out), .p2Out(p2Out),
    .busIn(busIn), .busOut(busOut), .busOe(busOe), .busRd(busRd),
    .busWr(busWr), .expSel(expSel), .expWrData(expWrData),
    .expRdData(expRdData), .expWr(expWr), .testPinAIn(testPinAIn),
    .testPinAOut(testPinAOut), .testPinAOe(testPinAOe),
    .testPinB(testPinB), .extIrqN(extIrqN), .extIrqReq(extIrqReq),
    .timerIrqReq(timerIrqReq), .timerFlag(timerFlag));
  mcs_ext_model mcs_ext_model_i (
    .mclk(mclk), .progAddr(progAddr), .progData(progData),
    .xAddr(xAddr), .xWrData(xWrData), .xRdData(xRdData), .xRd(xRd),
    .xWr(xWr), .expSel(expSel), .expWrData(expWrData),
    .expRdData(expRdData), .expWr(expWr));

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Record strobed outputs just after each edge
  always @(posedge mclk)
  begin
    #1;
    if (busWr === 1'b1)
      outs.push_back(busOut);
    if (xWr === 1'b1)
      xw.push_back(xWrData);
    if (timerIrqReq === 1'b1)
      sawTirq = 1'b1;
  end

  task automatic chk(input string what, input logic [15:0] seen, exp);
  begin
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  end
  endtask : chk

  task automatic summarize;
  begin
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask : summarize

  task automatic restart;
  begin
    @(posedge mclk);
    rst <= 1'b1;
    foreach (mcs_ext_model_i.rom[i])
      mcs_ext_model_i.rom[i] = 8'h00;
    foreach (mcs_ext_model_i.expQ[i])
      mcs_ext_model_i.expQ[i] = 4'h6;
    outs.delete();
    xw.delete();
    sawTirq = 1'b0;
    cyc = 0;
  end
  endtask : restart

  task automatic ld(input logic [11:0] a, input logic [31:0] w);
  begin
    for (int i = 0; i < 4; i++)
      mcs_ext_model_i.rom[a + 12'(i)] = w[31 - 8 * i -: 8];
  end
  endtask : ld

  task automatic start;
  begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
  end
  endtask : start

  // Run to an address; exp < 0 skips the edge count
  task automatic upto(input logic [11:0] a, input int exp);
  begin
    while (progAddr !== a && cyc < 400)
    begin
      @(posedge mclk);
      #1;
      cyc++;
    end
    chk("address", {4'h0, progAddr}, {4'h0, a});
    if (exp >= 0)
      chk("edges", 16'(cyc), 16'(exp));
  end
  endtask : upto

  task automatic waitn(input int k);
    int n;
  begin
    n = 0;
    while (outs.size() < k && n < 300)
    begin
      @(posedge mclk);
      n++;
    end
    chk("bus writes", 16'(outs.size()), 16'(k));
  end
  endtask : waitn

  task automatic sc_branch;
  begin
    restart();
    ld(12'h000, 32'h0896_40c6);
    ld(12'h004, 32'h1000_0000);
    ld(12'h010, 32'h2660_0000);
    ld(12'h060, 32'h3670_4690);
    ld(12'h064, 32'h04ff_0000);
    ld(12'h0fc, 32'h0000_0056);
    ld(12'h100, 32'h8000_0000);
    busIn <= 8'h00;
    testPinAIn <= 1'b0;
    testPinB <= 1'b1;
    start();
    upto(12'h180, 16);
  end
  endtask : sc_branch

  task automatic sc_status;
  begin
    restart();
    ld(12'h000, 32'h08d7_a795);
    ld(12'h004, 32'hd5c7_0297);
    ld(12'h008, 32'hc595_c702);
    busIn <= 8'h20;
    start();
    waitn(2);
    chk("status word", {8'h0, outs[0]}, 16'h0098);
    chk("status word", {8'h0, outs[1]}, 16'h0028);
  end
  endtask : sc_status

  task automatic sc_call;
  begin
    restart();
    ld(12'h000, 32'ha7f5_1400);
    ld(12'h004, 32'hc702_e504);
    ld(12'h008, 32'h4000_0000);
    ld(12'h800, 32'h9793_0000);
    start();
    upto(12'h800, 4);
    upto(12'h040, 12);
    chk("restored status", {8'h0, outs[0]}, 16'h0088);
    chk("stack low", {8'h0, mcs_core_i.ram[8]}, 16'h0004);
    chk("stack high", {8'h0, mcs_core_i.ram[9]}, 16'h0080);
  end
  endtask : sc_call

  task automatic sc_io;
  begin
    restart();
    ld(12'h000, 32'h0802_9098);
    ld(12'h004, 32'h0f88_3099);
    ld(12'h008, 32'hf08a_0f3d);
    ld(12'h00c, 32'h9e0c_02a3);
    ld(12'h010, 32'h02e3_0298);
    ld(12'h014, 32'h0f88_3000);
    ld(12'h330, 32'h9900_0000);
    busIn <= 8'h5c;
    p1In <= 8'h3c;
    p2In <= 8'ha0;
    start();
    waitn(4);
    repeat (8) @(posedge mclk);
    chk("bus out", {8'h0, outs[0]}, 16'h005c);
    chk("data write", {8'h0, xw[0]}, 16'h005c);
    chk("port 1", {8'h0, p1Out}, 16'h0030);
    chk("port 2", {8'h0, p2Out}, 16'h00af);
    chk("nibble 5", {12'h0, mcs_ext_model_i.expQ[1]}, 16'h000c);
    chk("nibble 6", {12'h0, mcs_ext_model_i.expQ[2]}, 16'h0004);
    chk("nibble read", {8'h0, outs[1]}, 16'h0006);
    chk("table", {8'h0, outs[2]}, 16'h0030);
    chk("table 3", {8'h0, outs[3]}, 16'h0099);
    chk("bus latch", {8'h0, busOut}, 16'h0039);
  end
  endtask : sc_io

  task automatic sc_data;
  begin
    restart();
    ld(12'h000, 32'h0830_0245);
    ld(12'h004, 32'h1440_c702);
    ld(12'h008, 32'h4202_0408);
    ld(12'h040, 32'ha783_0000);
    busIn <= 8'ha5;
    testPinB <= 1'b1;
    start();
    upto(12'h008, 12);
    // Three falling edges on the event input
    repeat (3)
    begin
      @(posedge mclk);
      testPinB <= 1'b0;
      @(posedge mclk);
      testPinB <= 1'b1;
    end
    repeat (8) @(posedge mclk);
    chk("swap high nibble", {12'h0, outs[0][7:4]}, 16'h000a);
    chk("plain return", {8'h0, outs[1]}, 16'h0088);
    chk("event count", {8'h0, outs[$]}, 16'h0003);
  end
  endtask : sc_data

  task automatic sc_timer;
  begin
    restart();
    ld(12'h000, 32'h0862_4202);
    ld(12'h004, 32'h2555_160a);
    ld(12'h008, 32'h0406_6575);
    ld(12'h00c, 32'h0500_1581);
    busIn <= 8'hfe;
    extIrqN <= 1'b0;
    start();
    upto(12'h00a, 73);
    chk("counter move", {8'h0, outs[0]}, 16'h00fe);
    chk("timer flag", {15'h0, timerFlag}, 16'h0000);
    chk("timer request", {15'h0, sawTirq}, 16'h0001);
    upto(12'h00e, -1);
    chk("irq request", {15'h0, extIrqReq}, 16'h0001);
    chk("clock enable", {15'h0, testPinAOe}, 16'h0001);
    pinA = testPinAOut;
    @(posedge mclk);
    #1;
    chk("clock out", {15'h0, testPinAOut}, {15'h0, ~pinA});
    repeat (3) @(posedge mclk);
    #1;
    chk("irq request", {15'h0, extIrqReq}, 16'h0000);
  end
  endtask : sc_timer

  initial
  begin
    #200000;
    n_mismatch++;
    summarize();
  end

  initial
  begin
    rst = 1'b1;
    busIn = 8'h00;
    p1In = 8'hff;
    p2In = 8'hff;
    testPinAIn = 1'b1;
    testPinB = 1'b0;
    extIrqN = 1'b1;
    n_mismatch = 0;
    n_compared = 0;
    repeat (12) @(posedge mclk);
    sc_branch();
    sc_status();
    sc_call();
    sc_io();
    sc_data();
    sc_timer();
    summarize();
  end
endmodule : test_microcontroller_instruction_set
